// ---- adc_seq_defines.svh ----
/*
 * offsets, field positions, reset values and timing counts of the
 * sample sequencer block. assumes a byte-addressed 12-bit register port.
 */
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// common registers, byte addresses
`define OFS_ACTIVE    12'h000
`define OFS_RAW_IRQ   12'h004
`define OFS_IRQ_MASK  12'h008
`define OFS_IRQ_CLR   12'h00c
`define OFS_OVERFLOW  12'h010
`define OFS_TRIG_SEL  12'h014
`define OFS_UNDERFLOW 12'h018
`define OFS_PRIORITY  12'h020
`define OFS_INITIATE  12'h028
`define OFS_AVERAGE   12'h030
// per-sequencer window: 0x100 + 0x10 * n, word index inside
`define SEQ_WIN_HI    6'h04
`define SUB_MUX       2'h0
`define SUB_CTL       2'h1
`define SUB_FIFO      2'h2
`define SUB_FSTAT     2'h3
// control nibble bits
`define CTL_DIFF      0
`define CTL_END       1
`define CTL_IE        2
`define CTL_TEMP      3
// fifo status fields
`define FST_TAIL      0
`define FST_HEAD      4
`define FST_EMPTY     8
`define FST_FULL      12
// trigger codes
`define TRIG_CPU      4'h0
`define TRIG_EXT_MAX  4'h8
`define TRIG_ALWAYS   4'hf
// reset values
`define RST_PRIORITY  16'h3210
// timing
`define CLK_KHZ       50000
`define ADC_KHZ       16667
`define SAMPLE_KSPS   500
`define ADC_DIV       ((`CLK_KHZ + `ADC_KHZ - 1) / `ADC_KHZ)
`define SAMPLE_TICKS  ((`ADC_KHZ + `SAMPLE_KSPS - 1) / `SAMPLE_KSPS)

`endif

// ---- adc_seq_pkg.sv ----
/*
 * types shared by the sample sequencer block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package adc_seq_pkg;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

   typedef struct packed {
      logic       start;
      logic [2:0] pos_sel;
      logic [2:0] neg_sel;
      logic       diff;
      logic       temp;
   } conv_cmd_s;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_CONV  = 2'b11,
      ST_STORE = 2'b10
   } seq_state_e;

endpackage

// ---- adc_sample_sequencer.sv ----
/*
 * control logic of a four-sequencer 10-bit converter: triggers,
 * priority arbitration, step execution, averaging, result fifos and
 * interrupt flags. assumes the converter core answers each start with
 * a one-cycle conv_done on clk, and external triggers are asynchronous.
 */
// The plain strobed port and the placing of the registers were decided locally.
// Functional notes
// - every sample yields 10 bits; four inputs plus temperature sensor. the code selects among eight inputs (3-bit pos_sel).
// - four sequencers; steps and fifo depth 8, 4, 4, 1.
// - fifo entries are 32-bit words with the result in bits 9:0.
// - each step has an input nibble and a control nibble.
// - a sequencer runs only while its enable bit is set. the code lets a granted sequence run to its end after the bit clears.
// - the same input may appear in several steps.
// - any step may raise the raw interrupt.
// - the sequence ends after the step with its end flag set.
// - fifos are circular; reading the data address pops the oldest.
// - fifo status shows head, tail, full and empty.
// - push into full sets overflow; read of empty sets underflow.
// - converter timebase is a divider from clk aiming at 16.667 MHz.
// - only masked-in raw flags reach the interrupt output.
// - raw status and masked status are both readable.
// - writing one to the masked status bit clears that interrupt.
// - concurrent triggers served by priority value, 0 highest.
// - trigger source per sequencer chosen in trigger select register.
// - a software initiate bit starts a sequencer on processor trigger.
// - samples are paced at 500 ksps, back to back within a sequence.
// - one shared averager sums up to 64 conversions per entry.
// - averaging is off after reset.
// - differential pair k samples input 2k positive, 2k+1 negative.
`timescale 1ns/1ps
`include "adc_seq_defines.svh"
`default_nettype none

module adc_sample_sequencer #(
   parameter int NSEQ     = 4,
   parameter int NEXT     = 8,
   parameter int AVG_LOG  = 6
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire adc_seq_pkg::reg_req_s  reg_req,
   output logic [31:0]                 reg_rdata,
   input  wire logic [NEXT-1:0]        ext_trig,
   output adc_seq_pkg::conv_cmd_s      conv_cmd,
   input  wire logic                   conv_done,
   input  wire logic [9:0]             conv_data,
   output logic                        irq
);
   function automatic logic [3:0] seq_depth(input int i);
      return (i == 0) ? 4'd8 : ((i == NSEQ - 1) ? 4'd1 : 4'd4);
   endfunction
   logic [3:0]  active_q;
   logic [3:0]  raw_q;
   logic [3:0]  mask_q;
   logic [3:0]  ovf_q;
   logic [3:0]  unf_q;
   logic [3:0]  pend_q;
   logic [15:0] trig_sel_q;
   logic [15:0] pri_q;
   logic [2:0]  avg_q;
   logic [31:0] mux_q [NSEQ];
   logic [31:0] ctl_q [NSEQ];
   logic [31:0] reg_rdata_q;
   adc_seq_pkg::seq_state_e state_q;
   logic [1:0]  seq_q;
   logic [2:0]  step_q;
   logic [5:0]  avg_cnt_q;
   logic [15:0] acc_q;
   logic [1:0]  div_q;
   logic [5:0]  slot_q;
   logic        push_q;
   logic [9:0]  push_data_q;
   logic        ie_q;
   adc_seq_pkg::conv_cmd_s conv_cmd_q;
   logic [NEXT-1:0] ext_s1_q;
   logic [NEXT-1:0] ext_s2_q;
   logic [NEXT-1:0] ext_s3_q;
   // bus decode
   wire [11:0] addr     = reg_req.addr;
   wire        wr       = reg_req.wr;
   wire        rd       = reg_req.rd;
   wire        in_win   = (addr[11:6] == `SEQ_WIN_HI);
   wire [1:0]  win_seq  = addr[5:4];
   wire [1:0]  win_sub  = addr[3:2];
   wire        fifo_rd  = rd && in_win && (win_sub == `SUB_FIFO);
   wire [3:0]  irq_clr  = (wr && addr == `OFS_IRQ_CLR) ? reg_req.wdata[3:0] : 4'h0;
   wire [3:0]  ovf_clr  = (wr && addr == `OFS_OVERFLOW) ? reg_req.wdata[3:0] : 4'h0;
   wire [3:0]  unf_clr  = (wr && addr == `OFS_UNDERFLOW) ? reg_req.wdata[3:0] : 4'h0;
   wire [3:0]  initiate = (wr && addr == `OFS_INITIATE) ? reg_req.wdata[3:0] : 4'h0;
   // timebase and pacing
   wire        adc_en   = (div_q == 2'(`ADC_DIV - 1));
   wire        slot_ok  = (slot_q == 6'h00);
   wire [NEXT-1:0] ext_edge = ext_s2_q & ~ext_s3_q;
   // fifo side wires
   logic [9:0] fifo_head_w [NSEQ];
   logic [31:0] fstat_w    [NSEQ];
   logic [3:0] trig_hit;
   logic [3:0] pop;
   logic [3:0] push_ok;
   logic [3:0] ovf_set;
   logic [3:0] unf_set;
   // current step nibbles
   wire [3:0] cur_mux  = mux_q[seq_q][{step_q, 2'b00} +: 4];
   wire [3:0] cur_ctl  = ctl_q[seq_q][{step_q, 2'b00} +: 4];
   wire       last_avg = (avg_cnt_q == 6'((7'h01 << avg_q) - 7'h01));
   wire       last_step = cur_ctl[`CTL_END]
                        || ({1'b0, step_q} == seq_depth(int'(seq_q)) - 4'h1);

   genvar gi;
   generate
      for (gi = 0; gi < NSEQ; gi++) begin : g_seq
         localparam logic [3:0] DEPTH = seq_depth(gi);
         logic [9:0] mem [8];
         logic [2:0] head_q;
         logic [2:0] tail_q;
         logic [3:0] cnt_q;
         wire  [3:0] code  = trig_sel_q[4*gi +: 4];
         wire        full  = (cnt_q == DEPTH);
         wire        empty = (cnt_q == 4'h0);
         wire        sel   = (win_seq == 2'(gi));

         assign trig_hit[gi] = (code == `TRIG_CPU) ? initiate[gi]
                             : (code == `TRIG_ALWAYS) ? 1'b1
                             : (code <= `TRIG_EXT_MAX)
                               ? ext_edge[3'(code - 4'h1)] : 1'b0;
         assign pop[gi]      = fifo_rd && sel && !empty;
         assign unf_set[gi]  = fifo_rd && sel && empty;
         assign push_ok[gi]  = push_q && (seq_q == 2'(gi)) && !full;
         assign ovf_set[gi]  = push_q && (seq_q == 2'(gi)) && full;
         assign fifo_head_w[gi] = empty ? 10'h0 : mem[head_q];
         assign fstat_w[gi] = (32'(tail_q) << `FST_TAIL)
                            | (32'(head_q) << `FST_HEAD)
                            | (32'(empty) << `FST_EMPTY)
                            | (32'(full) << `FST_FULL);

         always_ff @(posedge clk) begin
            if (push_ok[gi]) begin
               mem[tail_q] <= push_data_q;
            end
         end

         // circular pointers wrap at the sequencer's own depth
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               head_q <= 3'h0;
               tail_q <= 3'h0;
               cnt_q  <= 4'h0;
            end else begin
               if (push_ok[gi]) begin
                  tail_q <= (tail_q == 3'(DEPTH - 4'h1)) ? 3'h0 : tail_q + 3'h1;
               end
               if (pop[gi]) begin
                  head_q <= (head_q == 3'(DEPTH - 4'h1)) ? 3'h0 : head_q + 3'h1;
               end
               cnt_q <= cnt_q + 4'(push_ok[gi]) - 4'(pop[gi]);
            end
         end
      end
   endgenerate

   // fixed-priority pick among pending sequencers
   logic       any_pend;
   logic [1:0] best;
   logic [1:0] best_pri;
   always_comb begin
      any_pend = 1'b0;
      best     = 2'h0;
      best_pri = 2'h3;
      for (int i = 0; i < NSEQ; i++) begin
         if (pend_q[i] && (!any_pend || pri_q[4*i +: 2] < best_pri)) begin
            any_pend = 1'b1;
            best     = 2'(i);
            best_pri = pri_q[4*i +: 2];
         end
      end
   end

   // read selection; the fifo word carries the result in its low bits
   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0;
      if (in_win) begin
         case (win_sub)
            `SUB_MUX:   rd_next = mux_q[win_seq];
            `SUB_CTL:   rd_next = ctl_q[win_seq];
            `SUB_FIFO:  rd_next = {22'h0, fifo_head_w[win_seq]};
            `SUB_FSTAT: rd_next = fstat_w[win_seq];
            default:    rd_next = 32'h0;
         endcase
      end else begin
         case (addr)
            `OFS_ACTIVE:    rd_next = {28'h0, active_q};
            `OFS_RAW_IRQ:   rd_next = {28'h0, raw_q};
            `OFS_IRQ_MASK:  rd_next = {28'h0, mask_q};
            `OFS_IRQ_CLR:   rd_next = {28'h0, raw_q & mask_q};
            `OFS_OVERFLOW:  rd_next = {28'h0, ovf_q};
            `OFS_TRIG_SEL:  rd_next = {16'h0, trig_sel_q};
            `OFS_UNDERFLOW: rd_next = {28'h0, unf_q};
            `OFS_PRIORITY:  rd_next = {16'h0, pri_q};
            `OFS_AVERAGE:   rd_next = {29'h0, avg_q};
            default:        rd_next = 32'h0;
         endcase
      end
   end

   // configuration registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         active_q   <= 4'h0;
         mask_q     <= 4'h0;
         trig_sel_q <= 16'h0;
         pri_q      <= `RST_PRIORITY;
         avg_q      <= 3'h0;
      end else if (wr) begin
         case (addr)
            `OFS_ACTIVE:   active_q   <= reg_req.wdata[3:0];
            `OFS_IRQ_MASK: mask_q     <= reg_req.wdata[3:0];
            `OFS_TRIG_SEL: trig_sel_q <= reg_req.wdata[15:0];
            `OFS_PRIORITY: pri_q      <= reg_req.wdata[15:0] & 16'h3333;
            `OFS_AVERAGE:  avg_q      <= (reg_req.wdata[2:0] > 3'(AVG_LOG))
                                         ? 3'(AVG_LOG) : reg_req.wdata[2:0];
            default: ;
         endcase
      end
   end

   // step nibbles; unused upper nibbles of short sequencers are kept zero
   generate
      for (gi = 0; gi < NSEQ; gi++) begin : g_cfg
         localparam logic [31:0] KEEP = (32'h1 << (4 * seq_depth(gi))) - 32'h1;
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               mux_q[gi] <= 32'h0;
               ctl_q[gi] <= 32'h0;
            end else if (wr && in_win && win_seq == 2'(gi)) begin
               if (win_sub == `SUB_MUX) begin
                  mux_q[gi] <= reg_req.wdata & KEEP;
               end
               if (win_sub == `SUB_CTL) begin
                  ctl_q[gi] <= reg_req.wdata & KEEP;
               end
            end
         end
      end
   endgenerate

   // sticky flags: a set in the clearing cycle wins
   wire [3:0] raw_set = {4{push_q && ie_q}} & (4'h1 << seq_q);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         raw_q <= 4'h0;
         ovf_q <= 4'h0;
         unf_q <= 4'h0;
      end else begin
         raw_q <= (raw_q & ~irq_clr) | raw_set;
         ovf_q <= (ovf_q & ~ovf_clr) | ovf_set;
         unf_q <= (unf_q & ~unf_clr) | unf_set;
      end
   end

   // trigger capture; a grant consumes the pending request
   wire [3:0] grant = (state_q == adc_seq_pkg::ST_IDLE && any_pend)
                      ? (4'h1 << best) : 4'h0;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pend_q <= 4'h0;
      end else begin
         pend_q <= ((pend_q & ~grant) | trig_hit) & active_q;
      end
   end

   // external trigger synchroniser and edge stage
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ext_s1_q <= '0;
         ext_s2_q <= '0;
         ext_s3_q <= '0;
      end else begin
         ext_s1_q <= ext_trig;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // converter timebase and sample slot pacing
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         div_q  <= 2'h0;
         slot_q <= 6'h0;
      end else begin
         div_q <= adc_en ? 2'h0 : div_q + 2'h1;
         if (conv_cmd_q.start) begin
            slot_q <= 6'(`SAMPLE_TICKS);
         end else if (adc_en && !slot_ok) begin
            slot_q <= slot_q - 6'h1;
         end
      end
   end

   // step commands to the converter core
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         conv_cmd_q <= '0;
      end else begin
         conv_cmd_q.start <= 1'b0;
         if (state_q == adc_seq_pkg::ST_WAIT && slot_ok) begin
            conv_cmd_q.start <= 1'b1;
            conv_cmd_q.diff  <= cur_ctl[`CTL_DIFF];
            conv_cmd_q.temp  <= cur_ctl[`CTL_TEMP];
            if (cur_ctl[`CTL_DIFF]) begin
               conv_cmd_q.pos_sel <= {cur_mux[1:0], 1'b0};
               conv_cmd_q.neg_sel <= {cur_mux[1:0], 1'b1};
            end else begin
               conv_cmd_q.pos_sel <= cur_mux[2:0];
               conv_cmd_q.neg_sel <= 3'h0;
            end
         end
      end
   end

   // sequence engine: runs a granted sequence to its end before rearbitrating
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q     <= adc_seq_pkg::ST_IDLE;
         seq_q       <= 2'h0;
         step_q      <= 3'h0;
         avg_cnt_q   <= 6'h0;
         acc_q       <= 16'h0;
         push_q      <= 1'b0;
         push_data_q <= 10'h0;
         ie_q        <= 1'b0;
      end else begin
         push_q <= 1'b0;
         case (state_q)
            adc_seq_pkg::ST_IDLE: begin
               if (any_pend) begin
                  seq_q     <= best;
                  step_q    <= 3'h0;
                  avg_cnt_q <= 6'h0;
                  acc_q     <= 16'h0;
                  state_q   <= adc_seq_pkg::ST_WAIT;
               end
            end
            adc_seq_pkg::ST_WAIT: begin
               if (slot_ok) begin
                  state_q <= adc_seq_pkg::ST_CONV;
               end
            end
            adc_seq_pkg::ST_CONV: begin
               if (conv_done) begin
                  acc_q <= acc_q + {6'h0, conv_data};
                  if (last_avg) begin
                     state_q <= adc_seq_pkg::ST_STORE;
                  end else begin
                     avg_cnt_q <= avg_cnt_q + 6'h1;
                     state_q   <= adc_seq_pkg::ST_WAIT;
                  end
               end
            end
            adc_seq_pkg::ST_STORE: begin
               push_q      <= 1'b1;
               push_data_q <= 10'(acc_q >> avg_q);
               ie_q        <= cur_ctl[`CTL_IE];
               avg_cnt_q   <= 6'h0;
               acc_q       <= 16'h0;
               if (last_step) begin
                  state_q <= adc_seq_pkg::ST_IDLE;
               end else begin
                  step_q  <= step_q + 3'h1;
                  state_q <= adc_seq_pkg::ST_WAIT;
               end
            end
            default: state_q <= adc_seq_pkg::ST_IDLE;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata_q <= 32'h0;
      end else begin
         reg_rdata_q <= rd ? rd_next : 32'h0;
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign conv_cmd  = conv_cmd_q;
   assign irq       = |(raw_q & mask_q);

endmodule

`default_nettype wire

// ---- conv_model.sv ----
/* behavioural converter core facing the sequencer's conversion port.
   assumes one clock shared with the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module conv_model (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire adc_seq_pkg::conv_cmd_s conv_cmd,
   input  wire logic                   slow,
   output logic                        conv_done,
   output logic [9:0]                  conv_data
);
   logic [9:0] val_q;
   logic [4:0] cnt_q;
   int         wait_q;
   // outside the answer cycle the bus shows the inverse, so a late sample is caught
   assign conv_data = conv_done ? val_q : ~val_q;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         val_q     <= 10'h000;
         cnt_q     <= 5'h00;
         wait_q    <= 0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= wait_q == 1;
         if (wait_q != 0)
            wait_q <= wait_q - 1;
         if (conv_cmd.start) begin
            val_q  <= {conv_cmd.diff, conv_cmd.temp, conv_cmd.temp ? 3'h0 : conv_cmd.pos_sel,
                       cnt_q};
            cnt_q  <= cnt_q + 5'h01;
            wait_q <= slow ? 20 : 2;
         end
      end
   end
endmodule
`default_nettype wire

// ---- adc_seq_assertions.sv ----
/* port-level assertions of the sample sequencer.
   assumes one clock domain and the register map of the defines header. */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_seq_checker #(
   parameter int NSEQ    = 4,
   parameter int NEXT    = 8,
   parameter int AVG_LOG = 6
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire adc_seq_pkg::reg_req_s  reg_req,
   input  wire logic [31:0]            reg_rdata,
   input  wire logic [NEXT-1:0]        ext_trig,
   input  wire adc_seq_pkg::conv_cmd_s conv_cmd,
   input  wire logic                   conv_done,
   input  wire logic [9:0]             conv_data,
   input  wire logic                   irq
);
   // one tick of slack for the phase of the converter timebase
   localparam int MIN_GAP = `ADC_DIV * (`SAMPLE_TICKS - 1);
   localparam int OFF_MAX = 1200;
   int         gap_q;
   int         off_q;
   logic       busy_q;
   logic       pri_wr_q;
   logic       avg_wr_q;
   logic [3:0] mask_q;
   logic [3:0] act_q;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gap_q    <= 4095;
         off_q    <= 0;
         busy_q   <= 1'b0;
         pri_wr_q <= 1'b0;
         avg_wr_q <= 1'b0;
         mask_q   <= 4'h0;
         act_q    <= 4'h0;
      end else begin
         gap_q    <= conv_cmd.start ? 1 : (gap_q < 4095 ? gap_q + 1 : gap_q);
         off_q    <= act_q != 4'h0 ? 0 : (off_q < 4095 ? off_q + 1 : off_q);
         busy_q   <= conv_cmd.start | (busy_q & ~conv_done);
         pri_wr_q <= pri_wr_q | (reg_req.wr && reg_req.addr == `OFS_PRIORITY);
         avg_wr_q <= avg_wr_q | (reg_req.wr && reg_req.addr == `OFS_AVERAGE);
         if (reg_req.wr && reg_req.addr == `OFS_IRQ_MASK)
            mask_q <= reg_req.wdata[3:0];
         if (reg_req.wr && reg_req.addr == `OFS_ACTIVE)
            act_q <= reg_req.wdata[3:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_pri_rd;
      reg_req.rd && reg_req.addr == `OFS_PRIORITY && !pri_wr_q;
   endsequence
   sequence s_avg_rd;
      reg_req.rd && reg_req.addr == `OFS_AVERAGE && !avg_wr_q;
   endsequence
   chk_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside the answer cycle");
   chk_prio_reset: assert property (s_pri_rd |=> reg_rdata[15:0] == `RST_PRIORITY)
      else $error("priority reset value wrong");
   chk_avg_off: assert property (s_avg_rd |=> reg_rdata == 32'h0)
      else $error("averaging not off after reset");
   chk_sel_hold: assert property (!conv_cmd.start |-> $stable({conv_cmd.pos_sel,
      conv_cmd.neg_sel, conv_cmd.diff, conv_cmd.temp}))
      else $error("selects changed without a start");
   chk_diff_pair: assert property (conv_cmd.start && conv_cmd.diff |-> !conv_cmd.pos_sel[0]
      && conv_cmd.neg_sel == conv_cmd.pos_sel + 3'h1)
      else $error("differential pair selects wrong");
   chk_start_gap: assert property (conv_cmd.start |-> gap_q >= MIN_GAP)
      else $error("conversion starts too close");
   chk_one_conv: assert property (conv_cmd.start |-> !busy_q)
      else $error("start while a conversion is outstanding");
   chk_start_enabled: assert property (conv_cmd.start |-> off_q < OFF_MAX)
      else $error("conversion with all sequencers disabled");
   chk_irq_mask: assert property (mask_q == 4'h0 |-> !irq)
      else $error("interrupt raised while fully masked");
endmodule
bind adc_sample_sequencer adc_seq_checker #(.NSEQ(NSEQ), .NEXT(NEXT), .AVG_LOG(AVG_LOG)) chk (
   .clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .ext_trig(ext_trig), .conv_cmd(conv_cmd), .conv_done(conv_done),
   .conv_data(conv_data), .irq(irq));
`default_nettype wire

// ---- testbench.sv ----
/* self-checking bench of the sample sequencer with a converter model.
   assumes the register map and timing of the defines header. */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module testbench;
   adc_seq_pkg::reg_req_s  req;
   adc_seq_pkg::conv_cmd_s cmd;
   logic        clk;
   logic        reset_n;
   logic [31:0] rdata;
   logic [7:0]  ext_trig;
   logic        done;
   logic [9:0]  cdata;
   logic        irq;
   logic        slow;
   logic [31:0] d;
   logic [2:0]  pos_q [$];
   logic [31:0] exp0  [5] = '{32'h40, 32'h41, 32'h242, 32'h103, 32'h64};
   int          failures;
   int          total_checks;
   int          sc;
   int          dc;
   int          cyc;
   adc_sample_sequencer dut (.clk(clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata),
      .ext_trig(ext_trig), .conv_cmd(cmd), .conv_done(done), .conv_data(cdata), .irq(irq));
   conv_model core (.clk(clk), .reset_n(reset_n), .conv_cmd(cmd), .slow(slow),
      .conv_done(done), .conv_data(cdata));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) begin
      if (cmd.start === 1'b1) begin
         pos_q.push_back(cmd.pos_sel);
         sc++;
      end
      if (done === 1'b1)
         dc++;
   end
   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         summarize();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      rd(a);
      check(d, exp);
   endtask
   // waits on the model's answers, then the store and fifo write cycles
   task automatic run_to(input int t);
      for (int i = 0; i < 3000 && dc < t; i++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      check(32'(dc), 32'(t));
   endtask
   initial begin
      req = '0;
      reset_n = 1'b0;
      ext_trig = 8'h00;
      slow = 1'b0;
      failures = 0;
      total_checks = 0;
      sc = 0;
      dc = 0;
      cyc = 0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rc(`OFS_PRIORITY, 32'h3210);
      rc(`OFS_AVERAGE, 32'h0);
      rc(`OFS_ACTIVE, 32'h0);
      rc(12'h10c, 32'h100);
      rc(12'h140, 32'h0);
      // step 1 repeats the input of step 0, the nibbles past step 4 are junk
      wr(12'h100, 32'h11130122);
      wr(12'h104, 32'h44468140);
      wr(12'h110, 32'h0);
      wr(12'h114, 32'h2);
      wr(12'h120, 32'h1);
      wr(12'h124, 32'h2);
      wr(12'h130, 32'h1);
      wr(12'h134, 32'h2);
      wr(`OFS_TRIG_SEL, 32'h0100);
      wr(`OFS_PRIORITY, 32'h3012);
      rc(`OFS_PRIORITY, 32'h3012);
      wr(`OFS_IRQ_MASK, 32'h1);
      wr(`OFS_INITIATE, 32'h1);
      repeat (150) @(posedge clk);
      check(32'(sc), 32'h0);
      wr(`OFS_ACTIVE, 32'hf);
      wr(`OFS_INITIATE, 32'h1);
      // both later triggers land while sequencer zero is still running
      repeat (10) @(posedge clk);
      ext_trig <= 8'h01;
      wr(`OFS_INITIATE, 32'h2);
      run_to(7);
      ext_trig <= 8'h00;
      check(32'(sc), 32'h7);
      check({29'h0, pos_q[5]}, 32'h1);
      check({29'h0, pos_q[6]}, 32'h0);
      for (int i = 0; i < 5; i++)
         rc(12'h108, exp0[i]);
      rc(12'h108, 32'h0);
      rc(`OFS_UNDERFLOW, 32'h1);
      rd(12'h10c);
      check(d & 32'h1100, 32'h100);
      rc(`OFS_RAW_IRQ, 32'h1);
      rc(`OFS_IRQ_CLR, 32'h1);
      check({31'h0, irq}, 32'h1);
      wr(`OFS_IRQ_CLR, 32'h0);
      rc(`OFS_RAW_IRQ, 32'h1);
      wr(`OFS_IRQ_CLR, 32'h1);
      rc(`OFS_RAW_IRQ, 32'h0);
      check({31'h0, irq}, 32'h0);
      rc(12'h128, 32'h25);
      rc(12'h118, 32'h6);
      slow <= 1'b1;
      wr(`OFS_INITIATE, 32'h8);
      run_to(8);
      wr(`OFS_INITIATE, 32'h8);
      run_to(9);
      rd(12'h13c);
      check(d & 32'h1000, 32'h1000);
      rc(`OFS_OVERFLOW, 32'h8);
      rc(12'h138, 32'h27);
      wr(`OFS_OVERFLOW, 32'h8);
      rc(`OFS_OVERFLOW, 32'h0);
      slow <= 1'b0;
      wr(`OFS_AVERAGE, 32'h2);
      rc(`OFS_AVERAGE, 32'h2);
      wr(`OFS_INITIATE, 32'h8);
      run_to(13);
      rc(12'h138, 32'h2a);
      // always trigger kept on the lowest priority; it refills the one-entry fifo
      wr(`OFS_AVERAGE, 32'h0);
      wr(`OFS_TRIG_SEL, 32'hf100);
      repeat (300) @(posedge clk);
      wr(`OFS_ACTIVE, 32'h0);
      repeat (150) @(posedge clk);
      check(32'(sc), 32'(dc));
      rc(`OFS_OVERFLOW, 32'h8);
      summarize();
   end
endmodule
`default_nettype wire
